// ===== design/akf_pkg.sv
package akf_pkg;

  // ==========================================================================
  // Sizes
  localparam int NPORT        = 8;
  localparam int PW           = 3;
  localparam int NRNG         = 8;
  localparam int WIDE_BYTES   = 57;
  localparam int NARROW_BYTES = 24;
  localparam int WIDE_W       = WIDE_BYTES * 8;
  localparam int NARROW_W     = NARROW_BYTES * 8;
  localparam int CNT_W        = 9;

  // ==========================================================================
  // Frame constants
  localparam logic [CNT_W-1:0] OFS_PLUS20 = 9'h014;
  localparam logic [CNT_W-1:0] OFS_PLUS40 = 9'h028;
  localparam logic [CNT_W-1:0] OFS_ZERO   = 9'h000;
  localparam logic [CNT_W-1:0] CNT_MAX    = 9'h1ff;
  localparam logic [3:0]       NIB_IPV6   = 4'h6;
  localparam logic [3:0]       NIB_IPV4   = 4'h4;

  // ==========================================================================
  // Register map (word addresses on the plain port)
  localparam logic [7:0] ADDR_LOOKUP_EN = 8'h00;
  localparam logic [7:0] ADDR_LEG_EN    = 8'h01;
  localparam logic [7:0] ADDR_MISC      = 8'h02;
  localparam logic [7:0] ADDR_RNG_TYPE  = 8'h03;
  localparam logic [7:0] ADDR_RNG_OFS   = 8'h04;
  localparam logic [7:0] ADDR_STATUS    = 8'h05;
  localparam logic [7:0] ADDR_BND_BASE  = 8'h08;
  localparam logic [7:0] ADDR_BND_LAST  = 8'h0f;

  // Field layouts
  localparam int MISC_LOOP_SEL3 = 0;
  localparam int MISC_MASQ_SEL2 = 1;
  localparam int MISC_VD_SEL3   = 2;
  localparam int MISC_CPU_SEL3  = 3;
  localparam int MISC_W         = 4;
  localparam int RTYPE_W        = 3;
  localparam int BND_LO_LSB     = 0;
  localparam int BND_HI_LSB     = 16;
  localparam int STAT_RNG_LSB   = 16;

  // Reset values
  localparam logic [2*NPORT-1:0]     LOOKUP_EN_RST = 16'h0000;
  localparam logic [NPORT-1:0]       LEG_EN_RST    = 8'h00;
  localparam logic [MISC_W-1:0]      MISC_RST      = 4'h0;
  localparam logic [NRNG*RTYPE_W-1:0] RNG_TYPE_RST = 24'h000000;
  localparam logic [7:0]             RNG_OFS_RST   = 8'h00;
  localparam logic [31:0]            BND_RST       = 32'h00000000;

  // Source mask kinds
  localparam logic [1:0] MASK_KIND0 = 2'h0;
  localparam logic [1:0] MASK_KIND1 = 2'h1;
  localparam logic [1:0] MASK_KIND2 = 2'h2;
  localparam logic [1:0] MASK_KIND3 = 2'h3;

  // ==========================================================================
  // Enumerations
  typedef enum logic {
    FT_ETHERNET     = 1'b0,
    FT_CONTROL_WORD = 1'b1
  } akf_ftype_e;

  typedef enum logic [2:0] {
    SRC_FRONT       = 3'b000,
    SRC_LOOPBACK    = 3'b001,
    SRC_MASQ        = 3'b010,
    SRC_VIRTUAL_DEV = 3'b011,
    SRC_CPU_INJECT  = 3'b100
  } akf_src_e;

  typedef enum logic [2:0] {
    FAM_NONE = 3'b000,
    FAM_IPV4 = 3'b001,
    FAM_IPV6 = 3'b010,
    FAM_LINK = 3'b011,
    FAM_RAW  = 3'b100
  } akf_family_e;

  typedef enum logic [2:0] {
    RNG_DST_PORT = 3'b000,
    RNG_SRC_PORT = 3'b001,
    RNG_ANY_PORT = 3'b010,
    RNG_VID      = 3'b011,
    RNG_DSCP     = 3'b100,
    RNG_FIELD    = 3'b101
  } akf_rng_e;

  typedef enum logic [1:0] {
    POS_LINK    = 2'b00,
    POS_PAYLOAD = 2'b01,
    POS_PLUS20  = 2'b10,
    POS_PLUS40  = 2'b11
  } akf_pos_e;

  typedef enum logic {
    ST_IDLE  = 1'b0,
    ST_FRAME = 1'b1
  } akf_state_e;

endpackage : akf_pkg

// ===== design/akf_key_builder.sv
module akf_key_builder
  import akf_pkg::*;
(
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_b,
  // Register port
  input  wire logic [7:0]           i_addr,
  input  wire logic [31:0]          i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic      [31:0]          o_rdata,
  // Frame metadata, valid with i_sof
  input  wire logic                 i_sof,
  input  wire akf_ftype_e           i_frame_type,
  input  wire logic [3:0]           i_first_nibble,
  input  wire logic                 i_is_ipv4,
  input  wire logic                 i_is_ipv6,
  input  wire logic                 i_is_tcp_udp,
  input  wire logic [7:0]           i_l3_pos,
  input  wire logic [7:0]           i_typelen_pos,
  input  wire akf_src_e             i_src_kind,
  input  wire logic [PW-1:0]        i_src_port,
  input  wire logic                 i_raw_key_enable,
  input  wire akf_pos_e             i_raw_key_position,
  input  wire logic                 i_routable_flag,
  input  wire logic [11:0]          i_classified_vid,
  input  wire logic [5:0]           i_classified_dscp,
  input  wire logic [11:0]          i_ingress_leg_vlan,
  input  wire logic [11:0]          i_egress_leg_vlan,
  input  wire logic [15:0]          i_l4_src_port,
  input  wire logic [15:0]          i_l4_dst_port,
  input  wire logic [47:0]          i_dest_mac_field,
  // Frame byte stream
  input  wire logic                 i_byte_valid,
  input  wire logic [7:0]           i_byte,
  input  wire logic                 i_eof,
  // Key contents
  output logic      [1:0]           o_key_valid,
  output akf_family_e               o_key_family,
  output logic      [47:0]          o_dest_mac_field,
  output logic      [11:0]          o_vid_lookup0,
  output logic      [11:0]          o_vid_lookup1,
  output logic      [NRNG-1:0]      o_range_match_vector,
  output logic      [1:0]           o_source_mask_kind,
  output logic      [NPORT-1:0]     o_source_port_bitmap,
  output logic                      o_raw_key_valid,
  output logic      [WIDE_W-1:0]    o_raw_wide,
  output logic      [NARROW_W-1:0]  o_raw_narrow
);

  // ==========================================================================
  // Helpers
  function automatic logic in_range(input logic [15:0] v, input logic [31:0] b);
    return (v >= b[BND_LO_LSB +: 16]) && (v <= b[BND_HI_LSB +: 16]);
  endfunction : in_range

  function automatic logic [NPORT-1:0] port_bit(input logic [PW-1:0] p);
    logic [NPORT-1:0] m;
    m    = '0;
    m[p] = 1'b1;
    return m;
  endfunction : port_bit

  // ==========================================================================
  // Configuration registers
  logic [2*NPORT-1:0]      lookup_enable;
  logic [NPORT-1:0]        router_leg_vlan_enable;
  logic [MISC_W-1:0]       misc_key_control;
  logic [NRNG*RTYPE_W-1:0] range_type_config;
  logic [7:0]              range_field_offset;
  logic [31:0]             range_bounds_config [NRNG];
  logic [15:0]             frame_count;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lookup_enable          <= LOOKUP_EN_RST;
      router_leg_vlan_enable <= LEG_EN_RST;
      misc_key_control       <= MISC_RST;
      range_type_config      <= RNG_TYPE_RST;
      range_field_offset     <= RNG_OFS_RST;
    end else if (i_wr) begin
      case (i_addr)
        ADDR_LOOKUP_EN: lookup_enable          <= i_wdata[2*NPORT-1:0];
        ADDR_LEG_EN:    router_leg_vlan_enable <= i_wdata[NPORT-1:0];
        ADDR_MISC:      misc_key_control       <= i_wdata[MISC_W-1:0];
        ADDR_RNG_TYPE:  range_type_config      <= i_wdata[NRNG*RTYPE_W-1:0];
        ADDR_RNG_OFS:   range_field_offset     <= i_wdata[7:0];
        default: begin
        end
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < NRNG; g++) begin : g_bnd
      always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          range_bounds_config[g] <= BND_RST;
        end else if (i_wr && (i_addr == ADDR_BND_BASE + 8'(g))) begin
          range_bounds_config[g] <= i_wdata;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Read port: data only in the cycle after the strobe
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    case (i_addr)
      ADDR_LOOKUP_EN: rd_mux[2*NPORT-1:0]      = lookup_enable;
      ADDR_LEG_EN:    rd_mux[NPORT-1:0]        = router_leg_vlan_enable;
      ADDR_MISC:      rd_mux[MISC_W-1:0]       = misc_key_control;
      ADDR_RNG_TYPE:  rd_mux[NRNG*RTYPE_W-1:0] = range_type_config;
      ADDR_RNG_OFS:   rd_mux[7:0]              = range_field_offset;
      ADDR_STATUS: begin
        rd_mux[15:0]                    = frame_count;
        rd_mux[STAT_RNG_LSB +: NRNG]    = o_range_match_vector;
      end
      default: begin
        if (i_addr >= ADDR_BND_BASE && i_addr <= ADDR_BND_LAST) begin
          rd_mux = range_bounds_config[i_addr[2:0]];
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= i_rd ? rd_mux : '0;
    end
  end

  // ==========================================================================
  // Per-frame decisions taken at start of frame
  akf_family_e      next_family;
  logic             next_raw_ok;
  logic [CNT_W-1:0] next_raw_start;
  logic [1:0]       next_mask_kind;
  logic [NPORT-1:0] next_bitmap;
  logic             next_is_ip;
  logic             leg_on;

  always_comb begin
    next_raw_ok    = i_raw_key_enable;
    next_raw_start = OFS_ZERO;
    // Control-word streams already begin at the payload
    case (i_raw_key_position)
      POS_LINK: begin
        next_raw_start = OFS_ZERO;
        if (i_frame_type == FT_CONTROL_WORD) next_raw_ok = 1'b0;
      end
      POS_PAYLOAD: begin
        next_raw_start = (i_frame_type == FT_CONTROL_WORD) ? OFS_ZERO
                                                           : CNT_W'(i_l3_pos);
      end
      POS_PLUS20: begin
        next_raw_start = ((i_frame_type == FT_CONTROL_WORD) ? OFS_ZERO
                                                            : CNT_W'(i_l3_pos)) + OFS_PLUS20;
      end
      POS_PLUS40: begin
        next_raw_start = ((i_frame_type == FT_CONTROL_WORD) ? OFS_ZERO
                                                            : CNT_W'(i_l3_pos)) + OFS_PLUS40;
      end
      default: next_raw_start = OFS_ZERO;
    endcase
  end

  always_comb begin
    next_family = FAM_LINK;
    if (next_raw_ok) begin
      next_family = FAM_RAW;
    end else if (i_frame_type == FT_CONTROL_WORD) begin
      if (i_first_nibble == NIB_IPV6)      next_family = FAM_IPV6;
      else if (i_first_nibble == NIB_IPV4) next_family = FAM_IPV4;
      else                                 next_family = FAM_NONE;
    end else if (i_is_ipv6) begin
      next_family = FAM_IPV6;
    end else if (i_is_ipv4) begin
      next_family = FAM_IPV4;
    end
    next_is_ip = (next_family == FAM_IPV4) || (next_family == FAM_IPV6);
  end

  always_comb begin
    next_bitmap    = port_bit(i_src_port);
    next_mask_kind = MASK_KIND0;
    case (i_src_kind)
      SRC_FRONT: next_mask_kind = MASK_KIND0;
      SRC_LOOPBACK: begin
        next_mask_kind = misc_key_control[MISC_LOOP_SEL3] ? MASK_KIND3
                                                          : MASK_KIND1;
      end
      SRC_MASQ: begin
        next_mask_kind = misc_key_control[MISC_MASQ_SEL2] ? MASK_KIND2
                                                          : MASK_KIND0;
      end
      SRC_VIRTUAL_DEV: begin
        next_mask_kind = misc_key_control[MISC_VD_SEL3] ? MASK_KIND3
                                                        : MASK_KIND0;
      end
      SRC_CPU_INJECT: begin
        next_bitmap    = '0;
        next_mask_kind = misc_key_control[MISC_CPU_SEL3] ? MASK_KIND3
                                                         : MASK_KIND0;
      end
      default: next_mask_kind = MASK_KIND0;
    endcase
  end

  assign leg_on = router_leg_vlan_enable[i_src_port] && i_routable_flag;

  // ==========================================================================
  // Latched frame context
  akf_state_e       state;
  akf_family_e      fr_family;
  logic             fr_raw_ok;
  logic [CNT_W-1:0] fr_raw_start;
  logic [CNT_W-1:0] fr_field_pos;
  logic [1:0]       fr_key_en;
  logic [11:0]      fr_vid0;
  logic [11:0]      fr_vid1;
  logic [11:0]      fr_cvid;
  logic [5:0]       fr_dscp;
  logic [15:0]      fr_sport;
  logic [15:0]      fr_dport;
  logic             fr_is_ip;
  logic             fr_tcp_udp;
  logic [47:0]      fr_dmac;
  logic [1:0]       fr_mask_kind;
  logic [NPORT-1:0] fr_bitmap;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE:  if (i_sof) state <= ST_FRAME;
        ST_FRAME: if (i_eof) state <= ST_IDLE;
        default:  state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fr_family    <= FAM_NONE;
      fr_raw_ok    <= 1'b0;
      fr_raw_start <= '0;
      fr_field_pos <= '0;
      fr_key_en    <= '0;
      fr_vid0      <= '0;
      fr_vid1      <= '0;
      fr_cvid      <= '0;
      fr_dscp      <= '0;
      fr_sport     <= '0;
      fr_dport     <= '0;
      fr_is_ip     <= 1'b0;
      fr_tcp_udp   <= 1'b0;
      fr_dmac      <= '0;
      fr_mask_kind <= MASK_KIND0;
      fr_bitmap    <= '0;
    end else if (state == ST_IDLE && i_sof) begin
      fr_family    <= next_family;
      fr_raw_ok    <= next_raw_ok;
      fr_raw_start <= next_raw_start;
      fr_field_pos <= CNT_W'(i_typelen_pos) + CNT_W'(range_field_offset);
      fr_key_en    <= {lookup_enable[NPORT + int'(i_src_port)],
                       lookup_enable[i_src_port]};
      fr_vid0      <= leg_on ? i_ingress_leg_vlan : i_classified_vid;
      fr_vid1      <= leg_on ? i_egress_leg_vlan  : i_classified_vid;
      fr_cvid      <= i_classified_vid;
      fr_dscp      <= i_classified_dscp;
      fr_sport     <= i_l4_src_port;
      fr_dport     <= i_l4_dst_port;
      fr_is_ip     <= next_is_ip;
      fr_tcp_udp   <= i_is_tcp_udp;
      // No link layer behind a popped label stack
      fr_dmac      <= (i_frame_type == FT_CONTROL_WORD) ? '0 : i_dest_mac_field;
      fr_mask_kind <= next_mask_kind;
      fr_bitmap    <= next_bitmap;
    end
  end

  // ==========================================================================
  // Byte capture: raw keys and selected field
  logic [CNT_W-1:0]    byte_cnt;
  logic [CNT_W-1:0]    raw_idx;
  logic [WIDE_W-1:0]   raw_wide;
  logic [NARROW_W-1:0] raw_narrow;
  logic [15:0]         sel_field;
  logic                take;

  assign take    = (state == ST_FRAME) && i_byte_valid;
  assign raw_idx = byte_cnt - fr_raw_start;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      byte_cnt <= '0;
    end else if (state == ST_IDLE) begin
      byte_cnt <= '0;
    end else if (take && byte_cnt != CNT_MAX) begin
      // Saturates; raw windows never reach that far
      byte_cnt <= byte_cnt + 9'h001;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      raw_wide   <= '0;
      raw_narrow <= '0;
    end else if (state == ST_IDLE && i_sof) begin
      // Short frames leave trailing bytes zero
      raw_wide   <= '0;
      raw_narrow <= '0;
    end else if (take && fr_raw_ok && byte_cnt >= fr_raw_start) begin
      if (raw_idx < CNT_W'(WIDE_BYTES)) begin
        raw_wide[8*(WIDE_BYTES-1-int'(raw_idx)) +: 8] <= i_byte;
      end
      if (raw_idx < CNT_W'(NARROW_BYTES)) begin
        raw_narrow[8*(NARROW_BYTES-1-int'(raw_idx)) +: 8] <= i_byte;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sel_field <= '0;
    end else if (state == ST_IDLE && i_sof) begin
      sel_field <= '0;
    end else if (take && byte_cnt == fr_field_pos) begin
      sel_field[15:8] <= i_byte;
    end else if (take && byte_cnt == fr_field_pos + 9'h001) begin
      sel_field[7:0] <= i_byte;
    end
  end

  // ==========================================================================
  // Range checkers
  logic [NRNG-1:0] rng_hit;

  generate
    for (g = 0; g < NRNG; g++) begin : g_rng
      akf_rng_e rtype;
      assign rtype = akf_rng_e'(range_type_config[g*RTYPE_W +: RTYPE_W]);
      always_comb begin
        case (rtype)
          RNG_DST_PORT: rng_hit[g] = fr_tcp_udp &&
                                     in_range(fr_dport, range_bounds_config[g]);
          RNG_SRC_PORT: rng_hit[g] = fr_tcp_udp &&
                                     in_range(fr_sport, range_bounds_config[g]);
          RNG_ANY_PORT: rng_hit[g] = fr_tcp_udp &&
                                     (in_range(fr_sport, range_bounds_config[g]) ||
                                      in_range(fr_dport, range_bounds_config[g]));
          RNG_VID:      rng_hit[g] = in_range(16'(fr_cvid), range_bounds_config[g]);
          RNG_DSCP:     rng_hit[g] = fr_is_ip &&
                                     in_range(16'(fr_dscp), range_bounds_config[g]);
          RNG_FIELD:    rng_hit[g] = in_range(sel_field, range_bounds_config[g]);
          default:      rng_hit[g] = 1'b0;
        endcase
      end
    end
  endgenerate

  // ==========================================================================
  // Key outputs, published on end of frame
  logic key_done;

  assign key_done = (state == ST_FRAME) && i_eof;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_key_valid <= '0;
    end else if (key_done && fr_family != FAM_NONE) begin
      o_key_valid <= fr_key_en;
    end else begin
      o_key_valid <= '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_key_family         <= FAM_NONE;
      o_dest_mac_field     <= '0;
      o_vid_lookup0        <= '0;
      o_vid_lookup1        <= '0;
      o_range_match_vector <= '0;
      o_source_mask_kind   <= MASK_KIND0;
      o_source_port_bitmap <= '0;
      o_raw_key_valid      <= 1'b0;
      o_raw_wide           <= '0;
      o_raw_narrow         <= '0;
    end else if (key_done) begin
      o_key_family         <= fr_family;
      o_dest_mac_field     <= fr_dmac;
      o_vid_lookup0        <= fr_vid0;
      o_vid_lookup1        <= fr_vid1;
      // Only the IP keys carry the range vector
      o_range_match_vector <= fr_is_ip ? rng_hit : '0;
      o_source_mask_kind   <= fr_mask_kind;
      o_source_port_bitmap <= fr_bitmap;
      o_raw_key_valid      <= fr_raw_ok;
      o_raw_wide           <= raw_wide;
      o_raw_narrow         <= raw_narrow;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      frame_count <= '0;
    end else if (key_done) begin
      frame_count <= frame_count + 16'h0001;
    end
  end

endmodule : akf_key_builder

// ===== testbench/akf_frame_src.sv
module akf_frame_src (
  // Control
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire logic [7:0] i_len,
  // Stream
  output logic            o_sof = 1'b0,
  output logic            o_byte_valid = 1'b0,
  output logic [7:0]      o_byte = 8'h00,
  output logic            o_eof = 1'b0
);
  logic [8:0] cnt = 9'h000;
  logic       on = 1'b0;
  // ========
  // Stream; idle byte line toggles so stale data never looks valid
  always_ff @(posedge i_clk) begin
    o_sof        <= i_go;
    o_byte_valid <= on && cnt < {1'b0, i_len};
    o_eof        <= on && cnt == {1'b0, i_len};
    o_byte       <= on ? cnt[7:0] : ~o_byte;
    on           <= i_go || (on && cnt < {1'b0, i_len});
    cnt          <= i_go ? 9'h000 : cnt + 9'h001;
  end
endmodule : akf_frame_src

// ===== testbench/akf_key_builder_checker.sv
module akf_key_builder_checker
  import akf_pkg::*;
(
  // Watched ports
  input wire logic             i_clk,
  input wire logic             i_rst_b,
  input wire logic             i_eof,
  input wire logic [1:0]       o_key_valid,
  input wire akf_family_e      o_key_family,
  input wire logic [NRNG-1:0]  o_range_match_vector,
  input wire logic [1:0]       o_source_mask_kind,
  input wire logic [NPORT-1:0] o_source_port_bitmap,
  input wire logic             o_raw_key_valid
);
  // ========
  // Properties
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  AST_KV_EOF: assert property (o_key_valid != 2'h0 |-> $past(i_eof))
    else $error("key valid without frame end");
  AST_KV_PULSE: assert property (o_key_valid != 2'h0 |=> o_key_valid == 2'h0)
    else $error("key valid too long");
  AST_NO_KEY: assert property (o_key_family == FAM_NONE |-> o_key_valid == 2'h0)
    else $error("key valid without family");
  AST_RAW: assert property (o_raw_key_valid == (o_key_family == FAM_RAW))
    else $error("raw valid disagrees with family");
  AST_RNG_IP: assert property (o_range_match_vector != 8'h00 |->
    o_key_family inside {FAM_IPV4, FAM_IPV6}) else $error("range vector on non-IP key");
  AST_HOLD: assert property (!$past(i_eof) |->
    $stable({o_source_mask_kind, o_source_port_bitmap})) else $error("mask moved");
  AST_LOOP_ONE: assert property (o_source_mask_kind == 2'h1 |->
    $onehot(o_source_port_bitmap)) else $error("kind 1 bitmap not one-hot");
  AST_MASQ_ONE: assert property (o_source_mask_kind == 2'h2 |->
    $onehot(o_source_port_bitmap)) else $error("kind 2 bitmap not one-hot");
endmodule : akf_key_builder_checker

bind akf_key_builder akf_key_builder_checker u_chk (.*);

// ===== testbench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import akf_pkg::*;
  // ========
  // Signals
  logic i_clk = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0, go = 1'b0;
  logic i_is_ipv4 = 1'b0, i_is_tcp_udp = 1'b0, i_raw_key_enable = 1'b0, i_routable_flag = 1'b0;
  logic i_is_ipv6 = 1'b0;
  logic [2:0] i_src_port = 3'h5;
  logic [7:0] i_addr = 8'h00, i_l3_pos = 8'h00, len = 8'h04, eb, i_byte;
  logic [31:0] i_wdata = 32'h0, o_rdata;
  logic [3:0] i_first_nibble = 4'h0;
  logic [11:0] i_classified_vid = 12'h123, o_vid_lookup0, o_vid_lookup1;
  logic [15:0] i_l4_src_port = 16'h0, i_l4_dst_port = 16'h0, nfr = 16'h0;
  akf_ftype_e i_frame_type = FT_ETHERNET;
  akf_src_e i_src_kind = SRC_FRONT;
  akf_pos_e i_raw_key_position = POS_LINK;
  akf_family_e o_key_family;
  logic i_sof, i_byte_valid, i_eof, o_raw_key_valid;
  logic [7:0] o_range_match_vector, o_source_port_bitmap;
  logic [1:0] o_key_valid, o_source_mask_kind;
  logic [47:0] o_dest_mac_field;
  logic [WIDE_W-1:0] o_raw_wide;
  logic [NARROW_W-1:0] o_raw_narrow;
  int checks = 0, mismatches = 0, cyc = 0;
  logic [8:0] rows [10] = '{{SRC_FRONT, 4'h0, 2'h0}, {SRC_FRONT, 4'hf, 2'h0},
    {SRC_LOOPBACK, 4'h0, 2'h1}, {SRC_LOOPBACK, 4'h1, 2'h3}, {SRC_MASQ, 4'h0, 2'h0},
    {SRC_MASQ, 4'h2, 2'h2}, {SRC_VIRTUAL_DEV, 4'h0, 2'h0}, {SRC_VIRTUAL_DEV, 4'h4, 2'h3},
    {SRC_CPU_INJECT, 4'h0, 2'h0}, {SRC_CPU_INJECT, 4'h8, 2'h3}};
  logic [31:0] bnd [8] = '{32'h00c80064, 32'h001f0010, 32'h000f000f, 32'h01230123,
    32'h002a002a, 32'h04050405, 32'hffff0000, 32'hffff00c9};
  akf_family_e cw_fam [3] = '{FAM_IPV6, FAM_IPV4, FAM_NONE};
  logic [3:0] cw_nib [3] = '{4'h6, 4'h4, 4'h5};
  akf_key_builder DUT (.*, .i_classified_dscp(6'h2a), .i_typelen_pos(8'h00),
    .i_dest_mac_field(48'ha1b2c3d4e5f6), .i_ingress_leg_vlan(i_classified_vid + 12'h001),
    .i_egress_leg_vlan(i_classified_vid + 12'h002));
  akf_frame_src u_src (.i_clk(i_clk), .i_go(go), .i_len(len), .o_sof(i_sof),
    .o_byte_valid(i_byte_valid), .o_byte(i_byte), .o_eof(i_eof));
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  // ========
  // Tasks
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask : rd_reg
  // Samples in the single cycle where key valid stands
  task automatic frame(input logic [7:0] l);
    @(posedge i_clk);
    len <= l;
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    repeat (int'(l) + 2) @(posedge i_clk);
    #1 nfr++;
  endtask : frame
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      conclude();
    end
  end
  // ========
  // Sequence
  initial begin
    repeat (16) @(posedge i_clk);
    chk({o_key_family, o_source_mask_kind, o_key_valid, o_rdata}, 64'h0);
    $display("reset done");
    i_rst_b <= 1'b1;
    wr_reg(ADDR_LOOKUP_EN, 32'h2020);
    foreach (rows[i]) begin
      i_src_kind <= akf_src_e'(rows[i][8:6]);
      wr_reg(ADDR_MISC, {28'h0, rows[i][5:2]});
      frame(8'h04);
      eb = (i_src_kind == SRC_CPU_INJECT) ? 8'h00 : 8'h20;
      chk({o_key_family, o_key_valid, o_source_mask_kind, o_source_port_bitmap},
        {FAM_LINK, 2'h3, rows[i][1:0], eb});
    end
    $display("mask rows done");
    wr_reg(ADDR_RNG_TYPE, 32'h001ac688);
    wr_reg(ADDR_RNG_OFS, 32'h4);
    foreach (bnd[i]) wr_reg(ADDR_BND_BASE + 8'(i), bnd[i]);
    i_is_ipv4 <= 1'b1;
    i_is_tcp_udp <= 1'b1;
    i_l4_src_port <= 16'h000f;
    i_l4_dst_port <= 16'h00c8;
    frame(8'h08);
    chk(o_range_match_vector,
      8'h3d);
    i_is_tcp_udp <= 1'b0;
    frame(8'h08);
    chk(o_range_match_vector, 8'h38);
    rd_reg(ADDR_STATUS, {8'h00, 8'h38, nfr});
    $display("range done");
    i_raw_key_enable <= 1'b1;
    i_raw_key_position <= POS_PLUS20;
    i_l3_pos <= 8'h03;
    frame(8'd100);
    chk({o_key_family, o_raw_key_valid}, {FAM_RAW, 1'b1});
    chk({o_raw_wide[455:448], o_raw_wide[7:0], o_raw_narrow[191:184], o_raw_narrow[7:0]},
      32'h174f172e);
    i_raw_key_enable <= 1'b0;
    i_frame_type <= FT_CONTROL_WORD;
    for (int i = 0; i < 3; i++) begin
      i_first_nibble <= cw_nib[i];
      frame(8'h04);
      chk({o_key_family, o_key_valid, o_dest_mac_field},
        {cw_fam[i], i < 2 ? 2'h3 : 2'h0, 48'h0});
    end
    i_raw_key_enable <= 1'b1;
    i_raw_key_position <= POS_PLUS40;
    frame(8'd100);
    chk({o_raw_key_valid, o_raw_wide[455:448], o_raw_narrow[7:0]},
      {1'b1, 8'h28, 8'h3f});
    i_raw_key_position <= POS_LINK;
    frame(8'h04);
    chk({o_key_family, o_raw_key_valid}, {FAM_NONE, 1'b0});
    i_raw_key_enable <= 1'b0;
    $display("raw and control word done");
    i_frame_type <= FT_ETHERNET;
    i_src_kind <= SRC_FRONT;
    wr_reg(ADDR_LEG_EN, 32'h20);
    wr_reg(ADDR_LOOKUP_EN, 32'h2000);
    i_routable_flag <= 1'b1;
    frame(8'h04);
    chk({o_vid_lookup0, o_vid_lookup1, o_key_valid},
      {12'h124, 12'h125, 2'h2});
    i_src_port <= 3'h2;
    frame(8'h04);
    chk({o_vid_lookup0, o_vid_lookup1, o_key_valid, o_source_port_bitmap},
      {12'h123, 12'h123, 2'h0, 8'h04});
    i_routable_flag <= 1'b0;
    i_src_port <= 3'h5;
    i_is_ipv6 <= 1'b1;
    frame(8'h04);
    chk({o_vid_lookup0, o_vid_lookup1, o_key_family, o_range_match_vector},
      {12'h123, 12'h123, FAM_IPV6, 8'h18});
    rd_reg(8'h06, 32'h0);
    rd_reg(ADDR_LOOKUP_EN, 32'h2000);
    $display("vlan and registers done");
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk({o_key_family, o_key_valid, o_source_port_bitmap, o_range_match_vector, o_rdata}, 64'h0);
    i_rst_b <= 1'b1;
    rd_reg(ADDR_LOOKUP_EN, 32'h0);
    frame(8'h04);
    chk(o_key_valid, 2'h0);
    $display("mid-run reset done");
    conclude();
  end
endmodule : tb_top
